// ==== hdl/dma_flow_map.vh ====
// Constants for the two-channel DMA request flow: codes, field positions, reset values
`ifndef DMA_FLOW_MAP_VH
`define DMA_FLOW_MAP_VH
// Request source codes (four-bit field per channel)
`define SRC_EXT_DUAL     4'h0
`define SRC_EXT_MEM_DEV  4'h2
`define SRC_EXT_DEV_MEM  4'h3
`define SRC_AUTO         4'h4
`define SRC_TIMER0       4'h6
`define SRC_TIMER1       4'h7
`define SRC_TIMER2       4'h8
`define SRC_CONV_END     4'hB
`define SRC_SER0_TX      4'hC
`define SRC_SER0_RX      4'hD
`define SRC_SER1_TX      4'hE
`define SRC_SER1_RX      4'hF
// Transfer size codes {size_select_hi, size_select_lo}
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_LONG        2'h2
`define SIZE_BAD         2'h3
// Peripheral request vector bit positions
`define PREQ_TIMER0      0
`define PREQ_TIMER1      1
`define PREQ_TIMER2      2
`define PREQ_CONV_END    3
`define PREQ_SER0_TX     4
`define PREQ_SER0_RX     5
`define PREQ_SER1_TX     6
`define PREQ_SER1_RX     7
// Reset values and widths
`define COUNT_WIDTH      24
`define COUNT_RESET      24'h000000
`define ADDR_RESET       32'h00000000
`endif

// ==== hdl/request_latch.v ====
// Per-channel request detector: pin level or falling edge, and peripheral request selection
`timescale 1ns/1ns
`include "dma_flow_map.vh"
module request_latch (
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       armed,
	input  wire [3:0] source_sel,
	input  wire       request_detect_select,
	input  wire       ext_low_sync,
	input  wire       ext_fall,
	input  wire [7:0] periph_req,
	input  wire       take,
	output reg        pending
);
	// ************************************************************
	// Request decode
	// ************************************************************
	reg  raw;
	// Auto mode requests itself; pin sources honour the detect select
	always @* begin
		case (source_sel)
			`SRC_AUTO:        raw = 1'b1;
			`SRC_EXT_DUAL,
			`SRC_EXT_MEM_DEV,
			`SRC_EXT_DEV_MEM: raw = request_detect_select ? ext_fall : ext_low_sync;
			`SRC_TIMER0:      raw = periph_req[`PREQ_TIMER0];
			`SRC_TIMER1:      raw = periph_req[`PREQ_TIMER1];
			`SRC_TIMER2:      raw = periph_req[`PREQ_TIMER2];
			`SRC_CONV_END:    raw = periph_req[`PREQ_CONV_END];
			`SRC_SER0_TX:     raw = periph_req[`PREQ_SER0_TX];
			`SRC_SER0_RX:     raw = periph_req[`PREQ_SER0_RX];
			`SRC_SER1_TX:     raw = periph_req[`PREQ_SER1_TX];
			`SRC_SER1_RX:     raw = periph_req[`PREQ_SER1_RX];
			default:          raw = 1'b0;                                  // Prohibited codes never request
		endcase
	end

	// ************************************************************
	// Pending request
	// ************************************************************
	// An edge is remembered until served; a new request wins over the take
	always @(posedge sys_clk) begin
		if (rst || !armed)
			pending <= 1'b0;
		else if (raw)
			pending <= 1'b1;
		else if (take)
			pending <= 1'b0;
	end
endmodule // request_latch

// ==== hdl/dma_request_flow.v ====
// Two-channel DMA transfer flow: enable check, unit transfers, end, abort and priority
`timescale 1ns/1ns
`include "dma_flow_map.vh"
module dma_request_flow #(
	parameter CW = `COUNT_WIDTH
) (
	input  wire          sys_clk,
	input  wire          rst,
	input  wire          master_enable,
	input  wire          nmi_event,
	input  wire          addr_error_event,
	input  wire          nmi_flag_clear,
	input  wire          address_error_flag_clear,
	input  wire [1:0]    channel_enable,
	input  wire [1:0]    end_interrupt_enable,
	input  wire [1:0]    transfer_end_flag_clear,
	input  wire [7:0]    request_source,
	input  wire [1:0]    request_detect_select,
	input  wire [1:0]    burst_mode,
	input  wire [1:0]    size_select_lo,
	input  wire [1:0]    size_select_hi,
	input  wire [1:0]    count_load,
	input  wire [CW-1:0] count_value,
	input  wire [31:0]   source_address,
	input  wire [31:0]   destination_address,
	input  wire [1:0]    ext_request_n,
	input  wire [7:0]    periph_irq,
	input  wire [7:0]    periph_irq_enable,
	input  wire          unit_done,
	output reg           nmi_flag,
	output reg           address_error_flag,
	output reg  [1:0]    transfer_end_flag,
	output reg  [1:0]    end_of_transfer_irq,
	output reg  [7:0]    periph_request_clear,
	output reg  [7:0]    cpu_irq,
	output reg  [CW-1:0] transfer_count0,
	output reg  [CW-1:0] transfer_count1,
	output reg           bus_request,
	output reg           unit_start,
	output reg           active_channel,
	output reg  [1:0]    unit_size,
	output reg           dual_mode,
	output reg  [31:0]   read_address,
	output reg  [31:0]   write_address,
	output reg  [1:0]    transfer_acknowledge,
	output reg           ack_to_device
);
	// ************************************************************
	// Helper functions
	// ************************************************************
	// Peripheral vector bit served by a source code; 8 means none
	function [3:0] periph_index;
		input [3:0] src;
		begin
			case (src)
				`SRC_TIMER0:   periph_index = 4'h0;
				`SRC_TIMER1:   periph_index = 4'h1;
				`SRC_TIMER2:   periph_index = 4'h2;
				`SRC_CONV_END: periph_index = 4'h3;
				`SRC_SER0_TX:  periph_index = 4'h4;
				`SRC_SER0_RX:  periph_index = 4'h5;
				`SRC_SER1_TX:  periph_index = 4'h6;
				`SRC_SER1_RX:  periph_index = 4'h7;
				default:       periph_index = 4'h8;
			endcase
		end
	endfunction

	function is_single;
		input [3:0] src;
		begin
			is_single = (src == `SRC_EXT_MEM_DEV) || (src == `SRC_EXT_DEV_MEM);
		end
	endfunction

	// ************************************************************
	// Pin synchronisers and edge detect
	// ************************************************************
	reg  [1:0] pin_meta;
	reg  [1:0] pin_sync;
	reg  [1:0] pin_prev;
	// Request pins come from outside, two flops before any use
	always @(posedge sys_clk) begin
		if (rst) begin
			pin_meta <= 2'h3;
			pin_sync <= 2'h3;
			pin_prev <= 2'h3;
		end else begin
			pin_meta <= ext_request_n;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	wire [1:0] ext_low  = ~pin_sync;
	wire [1:0] ext_fall = pin_prev & ~pin_sync;

	// ************************************************************
	// Global flags
	// ************************************************************
	// State lives here: the address-error flag only latches while the state machine is out of ST_IDLE (ST_XFER or ST_NEXT)
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_XFER = 3'b010;
	localparam [2:0] ST_NEXT = 3'b100;
	reg  [2:0]    state;
	wire          busy = (state != ST_IDLE);
	// Event wins over a clear arriving in the same cycle
	always @(posedge sys_clk) begin
		if (rst) begin
			nmi_flag           <= 1'b0;
			address_error_flag <= 1'b0;
		end else begin
			if (nmi_event)
				nmi_flag <= 1'b1;
			else if (nmi_flag_clear)
				nmi_flag <= 1'b0;
			if (addr_error_event && busy)
				address_error_flag <= 1'b1;
			else if (address_error_flag_clear)
				address_error_flag <= 1'b0;
		end
	end

	// ************************************************************
	// Channel enable check and request detection
	// ************************************************************
	wire [1:0] size_bad = {({size_select_hi[1], size_select_lo[1]} == `SIZE_BAD),
	                       ({size_select_hi[0], size_select_lo[0]} == `SIZE_BAD)};
	// Prohibited size blocks the channel rather than moving an odd unit
	wire [1:0] armed = channel_enable & {2{master_enable}} & ~transfer_end_flag
	                   & {2{~nmi_flag & ~address_error_flag}} & ~size_bad;
	// A peripheral line counts only with its own interrupt enable set
	wire [7:0] periph_req = periph_irq & periph_irq_enable;
	wire [1:0] pending;
	reg  [1:0] take;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			request_latch u_req (
				.sys_clk               (sys_clk),
				.rst                   (rst),
				.armed                 (armed[g]),
				.source_sel            (request_source[4*g+3:4*g]),
				.request_detect_select (request_detect_select[g]),
				.ext_low_sync          (ext_low[g]),
				.ext_fall              (ext_fall[g]),
				.periph_req            (periph_req),
				.take                  (take[g]),
				.pending               (pending[g])
			);
		end
	endgenerate

	// ************************************************************
	// Transfer state machine
	// ************************************************************
	reg  [2:0]    next_state;
	reg           next_chan;
	reg  [CW-1:0] cur_count;
	reg  [3:0]    cur_src;
	wire          cur_armed = armed[active_channel];
	// A latched request whose channel was disarmed since is never taken
	wire [1:0]    ready = pending & armed;
	wire          last_unit = (cur_count == {{(CW-1){1'b0}}, 1'b1});

	always @* begin
		cur_count = active_channel ? transfer_count1 : transfer_count0;
		cur_src   = active_channel ? request_source[7:4] : request_source[3:0];
		next_chan = ~ready[0];
		take      = 2'h0;
		next_state = state;
		case (state)
			ST_IDLE:
				if (ready != 2'h0) begin
					take[next_chan] = 1'b1;
					next_state = ST_XFER;
				end
			ST_XFER:
				// Losing an enable or a flag drops the transfer at once
				if (!cur_armed)
					next_state = ST_IDLE;
				else if (unit_done)
					next_state = ST_NEXT;
			ST_NEXT:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	// Burst holds the bus across units of the same channel
	always @(posedge sys_clk) begin
		if (rst) begin
			state          <= ST_IDLE;
			active_channel <= 1'b0;
			bus_request    <= 1'b0;
			unit_start     <= 1'b0;
		end else begin
			state      <= next_state;
			unit_start <= (state == ST_IDLE) && (next_state == ST_XFER);
			if (state == ST_IDLE && next_state == ST_XFER)
				active_channel <= next_chan;
			if (next_state == ST_XFER)
				bus_request <= 1'b1;
			else if (next_state == ST_IDLE && !(burst_mode[active_channel] && pending[active_channel]
			         && cur_armed))
				bus_request <= 1'b0;
		end
	end

	// ************************************************************
	// Unit setup: size, address mode, acknowledge
	// ************************************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			unit_size            <= `SIZE_BYTE;
			dual_mode            <= 1'b1;
			read_address         <= `ADDR_RESET;
			write_address        <= `ADDR_RESET;
			transfer_acknowledge <= 2'h0;
			ack_to_device        <= 1'b0;
		end else begin
			if (state == ST_IDLE && next_state == ST_XFER) begin
				unit_size     <= next_chan ? {size_select_hi[1], size_select_lo[1]}
				                           : {size_select_hi[0], size_select_lo[0]};
				dual_mode     <= ~is_single(request_source[4*next_chan+:4]);
				read_address  <= source_address;
				write_address <= destination_address;
				// Memory to device means the acknowledged device receives
				ack_to_device <= (request_source[4*next_chan+:4] == `SRC_EXT_MEM_DEV);
			end
			transfer_acknowledge <= 2'h0;
			if (next_state == ST_XFER && is_single(next_state == state ? cur_src
			    : request_source[4*next_chan+:4]))
				transfer_acknowledge[state == ST_IDLE ? next_chan : active_channel] <= 1'b1;
		end
	end

	// ************************************************************
	// Counts, end flags and end interrupt
	// ************************************************************
	wire unit_ok = (state == ST_XFER) && unit_done && cur_armed;
	always @(posedge sys_clk) begin
		if (rst) begin
			transfer_count0   <= `COUNT_RESET;
			transfer_count1   <= `COUNT_RESET;
			transfer_end_flag <= 2'h0;
		end else begin
			if (count_load[0])
				transfer_count0 <= count_value;
			else if (unit_ok && !active_channel)
				transfer_count0 <= transfer_count0 - {{(CW-1){1'b0}}, 1'b1};
			if (count_load[1])
				transfer_count1 <= count_value;
			else if (unit_ok && active_channel)
				transfer_count1 <= transfer_count1 - {{(CW-1){1'b0}}, 1'b1};
			// Setting on the final unit beats a clear in the same cycle
			if (unit_ok && !active_channel && last_unit)
				transfer_end_flag[0] <= 1'b1;
			else if (transfer_end_flag_clear[0])
				transfer_end_flag[0] <= 1'b0;
			if (unit_ok && active_channel && last_unit)
				transfer_end_flag[1] <= 1'b1;
			else if (transfer_end_flag_clear[1])
				transfer_end_flag[1] <= 1'b0;
		end
	end

	// Level interrupt, follows the sticky end flag
	always @(posedge sys_clk) begin
		if (rst)
			end_of_transfer_irq <= 2'h0;
		else
			end_of_transfer_irq <= transfer_end_flag & end_interrupt_enable;
	end

	// ************************************************************
	// Peripheral request routing and clearing
	// ************************************************************
	reg  [7:0] claimed;
	reg  [7:0] next_clear;
	reg  [3:0] idx;
	integer    c;
	// Lines claimed by an enabled channel are hidden from the CPU
	always @* begin
		claimed    = 8'h00;
		next_clear = 8'h00;
		idx        = 4'h8;
		for (c = 0; c < 2; c = c + 1) begin
			idx = periph_index(request_source[4*c+:4]);
			if (idx != 4'h8 && channel_enable[c] && master_enable)
				claimed[idx[2:0]] = 1'b1;
		end
		idx = periph_index(cur_src);
		// Steal clears on every unit; burst waits for the final one
		if (unit_ok && idx != 4'h8 && (!burst_mode[active_channel] || last_unit))
			next_clear[idx[2:0]] = 1'b1;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			cpu_irq              <= 8'h00;
			periph_request_clear <= 8'h00;
		end else begin
			cpu_irq              <= periph_req & ~claimed;
			periph_request_clear <= next_clear;
		end
	end
endmodule // dma_request_flow

// ==== test/far_side_model.sv ====
// Far-side model: memory bus completion, request pins and peripheral interrupt sources
`timescale 1ns/1ns
module far_side_model (
	input  wire       sys_clk,
	input  wire       rst,
	input  wire [3:0] done_delay,
	input  wire       unit_start,
	input  wire [1:0] pin_ask,
	input  wire [7:0] irq_raise,
	input  wire [7:0] periph_request_clear,
	output reg        unit_done,
	output wire [1:0] ext_request_n,
	output reg  [7:0] periph_irq
);
	// ****
	// Requesters and bus side
	// ****
	reg [3:0] wait_left;
	reg       busy;
	// Pins are pulled up, so an idle requester reads high; it never moves data itself
	assign ext_request_n = ~pin_ask;
	// Each unit ends a chosen number of cycles after it starts; slow answers expose abort paths
	always @(posedge sys_clk) begin
		unit_done <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
			wait_left <= 4'h0;
		end else if (unit_start) begin
			busy <= 1'b1;
			wait_left <= done_delay;
		end else if (busy && wait_left <= 4'h1) begin
			busy <= 1'b0;
			unit_done <= 1'b1;
		end else if (busy) begin
			wait_left <= wait_left - 4'h1;
		end
	end
	// A module interrupt stays up until the controller clears it
	always @(posedge sys_clk) begin
		if (rst) begin
			periph_irq <= 8'h00;
		end else begin
			periph_irq <= (periph_irq | irq_raise) & ~periph_request_clear;
		end
	end
endmodule // far_side_model

// ==== test/dma_flow_sva.sv ====
// Port-level checker for the two-channel DMA request flow, with its bind
`timescale 1ns/1ns
module dma_flow_checker #(
	parameter CW = 24
) (
	input wire          sys_clk,
	input wire          rst,
	input wire          master_enable,
	input wire [1:0]    channel_enable,
	input wire          nmi_event,
	input wire [7:0]    request_source,
	input wire [1:0]    size_select_lo,
	input wire [1:0]    size_select_hi,
	input wire [1:0]    count_load,
	input wire [1:0]    end_interrupt_enable,
	input wire          unit_done,
	input wire          nmi_flag,
	input wire          address_error_flag,
	input wire [1:0]    transfer_end_flag,
	input wire [1:0]    end_of_transfer_irq,
	input wire [CW-1:0] transfer_count0,
	input wire          bus_request,
	input wire          unit_start,
	input wire          active_channel,
	input wire [1:0]    unit_size,
	input wire          dual_mode,
	input wire [1:0]    transfer_acknowledge,
	input wire          ack_to_device
);
	// ****
	// Unit tracking and properties
	// ****
	reg in_unit;
	// Completions outside a running unit must not count as transfers
	always @(posedge sys_clk) begin
		if (rst) begin
			in_unit <= 1'b0;
		end else if (unit_start) begin
			in_unit <= 1'b1;
		end else if (unit_done || !bus_request) begin
			in_unit <= 1'b0;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_ch0_unit_end;
		in_unit && !active_channel && unit_done && master_enable && channel_enable[0] && !nmi_flag
			&& !address_error_flag && !transfer_end_flag[0] && !count_load[0];
	endsequence
	sequence s_ch0_last_unit;
		s_ch0_unit_end ##0 (transfer_count0 == 24'h000001);
	endsequence
	a_start_when_armed: assert property (
		unit_start |-> $past(master_enable & ~nmi_flag & ~address_error_flag)
		&& ($past(channel_enable) & (2'h1 << active_channel)) != 2'h0) else $error("unit started while disarmed");
	a_count_steps_down: assert property (
		s_ch0_unit_end |=> transfer_count0 == $past(transfer_count0) - 1'b1) else $error("count not decremented");
	a_end_at_zero: assert property (
		s_ch0_last_unit |=> transfer_end_flag[0]) else $error("end flag missing at zero");
	a_no_early_end: assert property (
		$rose(transfer_end_flag[0]) |-> transfer_count0 == 24'h000000) else $error("end flag before zero");
	a_irq_tracks_flag: assert property (
		end_of_transfer_irq == $past(transfer_end_flag & end_interrupt_enable)) else $error("end irq wrong");
	a_nmi_sets_flag: assert property (
		nmi_event |=> nmi_flag) else $error("nmi flag not set");
	a_abort_on_fault: assert property (
		(nmi_flag || address_error_flag) [*3] |-> !bus_request && !unit_start) else $error("no abort on fault");
	a_abort_on_disable: assert property (
		(!master_enable) [*3] |-> !bus_request) else $error("no abort on master disable");
	a_mode_select: assert property (
		unit_start && !active_channel |-> dual_mode == ($past(request_source[3:1]) != 3'h1)) else $error("bad mode");
	a_ack_direction: assert property (
		unit_start && !active_channel && !dual_mode |-> transfer_acknowledge[0]
		&& (ack_to_device == !$past(request_source[0]))) else $error("bad acknowledge");
	a_ack_single_only: assert property (
		transfer_acknowledge != 2'h0 |-> !dual_mode) else $error("acknowledge in dual mode");
	a_size_passed: assert property (
		unit_start && !active_channel |-> unit_size == $past({size_select_hi[0], size_select_lo[0]})
		&& unit_size != 2'h3) else $error("bad unit size");
endmodule // dma_flow_checker
bind dma_request_flow dma_flow_checker #(.CW(CW)) flow_chk (
	.sys_clk              (sys_clk),
	.rst                  (rst),
	.master_enable        (master_enable),
	.channel_enable       (channel_enable),
	.nmi_event            (nmi_event),
	.request_source       (request_source),
	.size_select_lo       (size_select_lo),
	.size_select_hi       (size_select_hi),
	.count_load           (count_load),
	.end_interrupt_enable (end_interrupt_enable),
	.unit_done            (unit_done),
	.nmi_flag             (nmi_flag),
	.address_error_flag   (address_error_flag),
	.transfer_end_flag    (transfer_end_flag),
	.end_of_transfer_irq  (end_of_transfer_irq),
	.transfer_count0      (transfer_count0),
	.bus_request          (bus_request),
	.unit_start           (unit_start),
	.active_channel       (active_channel),
	.unit_size            (unit_size),
	.dual_mode            (dual_mode),
	.transfer_acknowledge (transfer_acknowledge),
	.ack_to_device        (ack_to_device)
);

// ==== test/two_channel_dma_request_flow_tb_top.sv ====
// Self-checking bench for the two-channel DMA request flow
`timescale 1ns/1ns
`include "dma_flow_map.vh"
module two_channel_dma_request_flow_tb_top;
	// ****
	// Wiring, clock and monitor
	// ****
	logic        sys_clk, rst, master_enable, nmi_event, addr_error_event, nmi_flag_clear, address_error_flag_clear;
	logic        unit_done, nmi_flag, address_error_flag, bus_request, unit_start, active_channel, dual_mode, ack_to_device;
	logic [1:0]  channel_enable, end_interrupt_enable, transfer_end_flag_clear, request_detect_select, burst_mode;
	logic [1:0]  size_select_lo, size_select_hi, count_load, ext_request_n, pin_ask, transfer_end_flag;
	logic [1:0]  end_of_transfer_irq, unit_size, transfer_acknowledge;
	logic [3:0]  done_delay;
	logic [7:0]  request_source, periph_irq, periph_irq_enable, periph_request_clear, cpu_irq, irq_raise, clr_seen, cpu_seen;
	logic [23:0] count_value, transfer_count0, transfer_count1;
	logic [31:0] source_address, destination_address, read_address, write_address;
	int          n_fail, tests_run, cycles;
	int          n_units [2];
	dma_request_flow #(.CW(24)) DUT (.*);
	far_side_model far_side (.*);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Pulses are collected here because a task may be waiting elsewhere when they occur
	always @(posedge sys_clk) begin
		cycles++;
		if (!rst && unit_start === 1'b1) n_units[active_channel]++;
		clr_seen |= periph_request_clear;
		cpu_seen |= cpu_irq;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ****
	// Shared tasks
	// ****
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task arm(input int ch, input logic [3:0] src, input logic [23:0] cnt, input logic [1:0] size);
		@(posedge sys_clk);
		request_source[ch*4 +: 4] <= src;
		{size_select_hi[ch], size_select_lo[ch]} <= size;
		count_value <= cnt;
		count_load[ch] <= 1'b1;
		@(posedge sys_clk);
		count_load <= 2'h0;
	endtask
	task clean;
		@(posedge sys_clk);
		{channel_enable, pin_ask, transfer_end_flag_clear} <= 6'h03;
		{master_enable, nmi_flag_clear, address_error_flag_clear} <= 3'h7;
		done_delay <= 4'h1;
		@(posedge sys_clk);
		{transfer_end_flag_clear, nmi_flag_clear, address_error_flag_clear} <= 4'h0;
		tick(3);
		n_units = '{0, 0};
		{clr_seen, cpu_seen} = 16'h0000;
	endtask
	task wait_end(input int ch);
		for (int i = 0; i < 300 && transfer_end_flag[ch] !== 1'b1; i++) @(posedge sys_clk);
		tick(2);
	endtask
	task raise(input logic [7:0] bits);
		irq_raise <= bits;
		@(posedge sys_clk);
		irq_raise <= 8'h00;
	endtask
	// ****
	// Scenarios
	// ****
	task t_reset;
		clean();
		arm(0, `SRC_AUTO, 24'h000005, `SIZE_BYTE);
		channel_enable <= 2'h1;
		tick(6);
		{rst, channel_enable} <= 3'h4;
		tick(2);
		rst <= 1'b0;
		tick(1);
		chk({nmi_flag, address_error_flag, transfer_end_flag, bus_request, dual_mode, transfer_count0}, 30'h01000000);
		$display("reset test done");
	endtask
	task t_auto;
		clean();
		end_interrupt_enable <= 2'h1;
		arm(0, `SRC_AUTO, 24'h000003, `SIZE_LONG);
		tick(5);
		chk(n_units[0], 0);
		channel_enable <= 2'h1;
		wait_end(0);
		tick(5);
		chk(n_units[0], 3);
		chk(transfer_count0, 24'h000000);
		chk(read_address, 32'h00001000);
		chk(write_address, 32'h00002000);
		chk(end_of_transfer_irq, 2'h1);
		clean();
		chk(end_of_transfer_irq, 2'h0);
		$display("auto-request test done");
	endtask
	task t_ext;
		logic [3:0] codes [3];
		codes = '{`SRC_EXT_DUAL, `SRC_EXT_MEM_DEV, `SRC_EXT_DEV_MEM};
		foreach (codes[i]) begin
			clean();
			request_detect_select <= 2'h0;
			arm(0, codes[i], 24'h000002, `SIZE_WORD);
			channel_enable <= 2'h1;
			tick(6);
			chk(n_units[0], 0);
			pin_ask <= 2'h1;
			wait_end(0);
			chk(n_units[0], 2);
		end
		clean();
		request_detect_select <= 2'h1;
		arm(0, `SRC_EXT_DUAL, 24'h000002, `SIZE_BYTE);
		{channel_enable, pin_ask} <= 4'h5;
		tick(30);
		chk(n_units[0], 1);
		chk(transfer_count0, 24'h000001);
		$display("external request test done");
	endtask
	task t_periph;
		logic [3:0] codes [8];
		codes = '{`SRC_TIMER0, `SRC_TIMER1, `SRC_TIMER2, `SRC_CONV_END, `SRC_SER0_TX, `SRC_SER0_RX, `SRC_SER1_TX, `SRC_SER1_RX};
		foreach (codes[i]) begin
			clean();
			periph_irq_enable <= 8'hFF;
			// Software points the source at the serving module's data register
			source_address <= 32'h00001000 + i;
			arm(1, codes[i], 24'h000001, `SIZE_BYTE);
			channel_enable <= 2'h2;
			raise(8'h01 << i);
			wait_end(1);
			chk(n_units[1], 1);
			chk(clr_seen, 8'h01 << i);
			chk(cpu_seen, 8'h00);
			chk(read_address, 32'h00001000 + i);
		end
		clean();
		burst_mode <= 2'h2;
		arm(1, `SRC_TIMER1, 24'h000002, `SIZE_BYTE);
		channel_enable <= 2'h2;
		raise(8'h02);
		wait_end(1);
		chk(n_units[1], 2);
		chk(clr_seen, 8'h02);
		clean();
		{burst_mode, periph_irq_enable} <= 10'h000;
		arm(1, `SRC_TIMER0, 24'h000001, `SIZE_BYTE);
		channel_enable <= 2'h2;
		raise(8'h01);
		tick(10);
		chk(n_units[1], 0);
		{channel_enable, periph_irq_enable} <= 10'h001;
		tick(3);
		chk(cpu_irq, 8'h01);
		channel_enable <= 2'h2;
		wait_end(1);
		chk(n_units[1], 1);
		$display("peripheral request test done");
	endtask
	task t_abort;
		for (int k = 0; k < 4; k++) begin
			clean();
			done_delay <= 4'h6;
			arm(0, `SRC_AUTO, 24'h000004, `SIZE_WORD);
			channel_enable <= 2'h1;
			tick(5);
			case (k)
				0: nmi_event <= 1'b1;
				1: addr_error_event <= 1'b1;
				2: master_enable <= 1'b0;
				default: channel_enable <= 2'h0;
			endcase
			@(posedge sys_clk);
			{nmi_event, addr_error_event} <= 2'h0;
			tick(20);
			chk(n_units[0], 1);
			chk(transfer_count0, 24'h000004);
			chk({transfer_end_flag, nmi_flag, address_error_flag}, k == 0 ? 4'h2 : k == 1 ? 4'h1 : 4'h0);
		end
		$display("abort test done");
	endtask
	task t_priority;
		clean();
		arm(0, `SRC_AUTO, 24'h000002, `SIZE_BYTE);
		arm(1, `SRC_AUTO, 24'h000002, `SIZE_BYTE);
		channel_enable <= 2'h3;
		for (int i = 0; i < 100 && n_units[1] == 0; i++) @(posedge sys_clk);
		chk(n_units[0], 2);
		wait_end(1);
		chk(transfer_count1, 24'h000000);
		clean();
		arm(0, `SRC_AUTO, 24'h000001, `SIZE_BAD);
		channel_enable <= 2'h1;
		tick(20);
		chk(n_units[0], 0);
		$display("priority and size test done");
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence: all inputs set at time zero, reset for four cycles
	initial begin
		{nmi_event, addr_error_event, nmi_flag_clear, address_error_flag_clear, master_enable} = 5'h01;
		{channel_enable, end_interrupt_enable, transfer_end_flag_clear, request_detect_select} = 8'h00;
		{burst_mode, size_select_lo, size_select_hi, count_load, pin_ask} = 10'h000;
		{request_source, periph_irq_enable, irq_raise, count_value} = 48'h0;
		{source_address, destination_address} = 64'h0000100000002000;
		done_delay = 4'h1;
		rst = 1'b1;
		tick(4);
		rst <= 1'b0;
		t_reset();
		t_auto();
		t_ext();
		t_periph();
		t_abort();
		t_priority();
		tally_and_finish();
	end
endmodule // two_channel_dma_request_flow_tb_top
